// File: design/adcbs_chain.sv
/*
 boundary-scan cells: a shift stage and an update stage per cell;
 assumes one-cycle capture, shift and update strobes from the caller.
*/
`timescale 1ns/10ps
module adcbs_chain #(
    parameter int N = 28,
    parameter logic [N-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_capture,
    input wire logic i_shift,
    input wire logic i_update,
    input wire logic i_si,
    input wire logic [N-1:0] i_par,
    output logic [N-1:0] o_update,
    output logic o_so
);
    logic [N-1:0] shreg;

    if (N < 2) begin : g_bad_len
        $error("chain needs at least two cells");
    end

    assign o_so = shreg[0];

    for (genvar b = 0; b < N; b++) begin : g_cell
        logic si_b;
        assign si_b = (b == N - 1) ? i_si : shreg[(b + 1) % N];
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                shreg[b] <= 1'b0;
            end else if (i_capture) begin
                shreg[b] <= i_par[b];
            end else if (i_shift) begin
                shreg[b] <= si_b;
            end
        end
        // update stage holds the applied value while shifting goes on
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_update[b] <= RESET_VAL[b];
            end else if (i_update) begin
                o_update[b] <= shreg[b];
            end
        end
    end
endmodule

// File: design/adcbs_pkg.sv
/*
 package for the converter boundary-scan segment: chain layout, idle pattern,
 register offsets and bus answers; assumes nothing of its surroundings.
*/
package adcbs_pkg;
    // chain length and cell positions, bit 0 sits next to the serial output
    localparam int CHAIN_LEN = 28;
    localparam int POS_COMP = 0;
    localparam int POS_CONV_PWR = 1;
    localparam int POS_AMP_PWR = 2;
    localparam int POS_SC_CLK = 3;
    localparam int POS_AMP_PATH = 4;
    localparam int POS_BG_NEG = 5;
    localparam int POS_DAC_LSB = 6;
    localparam int DAC_W = 10;
    localparam int POS_BYPASS = 16;
    localparam int POS_NEG_GND = 17;
    localparam int POS_HOLD = 18;
    localparam int POS_BG_REF = 19;
    localparam int POS_SEL_LSB = 20;
    localparam int SEL_W = 8;
    localparam logic [CHAIN_LEN-1:0] IDLE_PATTERN = 28'h015_8000;
    localparam logic [DAC_W-1:0] DAC_MIDPOINT = 10'h200;
    // synchroniser depth for the test-port pins
    localparam int SYNC_STAGES = 2;
    // register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_FUNC = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_SCAN = 12'h008;
    localparam int STAT_COMP = 0;
    localparam int STAT_EXTEST = 1;
    localparam int STAT_MID_OK = 2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: design/adcbs_sync.sv
/*
 two-stage synchroniser for a group of asynchronous level inputs;
 assumes the inputs are levels held longer than two clock periods.
*/
`timescale 1ns/10ps
module adcbs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// File: design/adcbs_top.sv
/*
 converter boundary-scan segment: cells between the approximation logic and
 the analog core, with an AXI4-Lite slave standing in for the digital side.
 assumes an outside tap controller driving tck and the dr state levels, and
 an analog comparator whose output is asynchronous to i_clk.
*/
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
// Notes on behaviour
// (RL1) one scan cell on each converter control and on the comparator result
// (RL2) idle pattern applied and digital side idle gives idle outputs, comp captured
// (RL3) converter_power_on at 1 powers the core; keep 0 when unused
// (RL4) amp_power_on at 1 powers the differential amplifier; keep 0 when unused
// (RL5) switchcap_clock clocks the switched-cap amplifier; idle 0
// (RL6) amp_path_enable at 1 routes amplifier to comparator; idle 0
// (RL7) bandgap_neg_select at 1 puts band-gap on comparator negative input; idle 0
// (RL8) ten comparison value cells, bits 9 to 0; idle only bit 9 set
// (RL9) bypass_ch_connect at 1 ties channels 0 to 3 to bypass path; idle 1
// (RL10) neg_input_ground at 1 grounds comparator negative input; idle 0
// (RL11) hold at 0 samples, at 1 holds; idle 1
// (RL12) with amplifier in use, hold rises only while switchcap_clock is 1; the segment does not gate hold, only the tap model sets the clock cell
// (RL13) bandgap_as_reference at 1 makes band-gap the converter reference; idle 0
// (RL14) eight input-select cells, bits 7 to 0; idle only bit 0 set
// (RL15) while sampling, comparison value held at midpoint 0x200; the segment applies o_dac as given, only the tap model forces it in extest
`timescale 1ns/10ps
module adcbs_top
    import adcbs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    // test port, already decoded by the tap controller
    input wire logic i_tck,
    input wire logic i_tdi,
    input wire logic i_capture_dr,
    input wire logic i_shift_dr,
    input wire logic i_update_dr,
    input wire logic i_extest,
    output logic o_tdo,
    // analog core
    input wire logic i_comp,
    output logic o_converter_power_on,
    output logic o_amp_power_on,
    output logic o_switchcap_clock,
    output logic o_amp_path_enable,
    output logic o_bandgap_neg_select,
    output logic [DAC_W-1:0] o_dac,
    output logic o_bypass_ch_connect,
    output logic o_neg_input_ground,
    output logic o_hold,
    output logic o_bandgap_as_reference,
    output logic [SEL_W-1:0] o_input_select,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [5:0] pin_s;
    logic tck_s, tdi_s, cap_s, shf_s, upd_s, extest_s;
    logic comp_s;
    logic tck_d;
    logic tck_rise, tck_fall;
    logic [CHAIN_LEN-1:0] upd;
    logic [CHAIN_LEN-1:0] func;
    logic [CHAIN_LEN-1:0] drive;
    logic [CHAIN_LEN-1:0] src;
    logic [CHAIN_LEN-1:0] par;
    logic chain_so;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_held, w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [31:0] wr_merge;

    adcbs_sync #(.WIDTH(6)) u_pin_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_tck, i_tdi, i_capture_dr, i_shift_dr, i_update_dr, i_extest}),
        .o_sync(pin_s)
    );
    // comparator is analog and free running, so it is synchronised too
    adcbs_sync #(.WIDTH(1)) u_comp_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_comp),
        .o_sync(comp_s)
    );
    assign {tck_s, tdi_s, cap_s, shf_s, upd_s, extest_s} = pin_s;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // (RL2) control cells capture what is applied
    // (RL1) comparator cell observes the result
    always_comb begin
        par = drive;
        par[POS_COMP] = comp_s;
    end

    // (RL1) one cell per control and result
    adcbs_chain #(.N(CHAIN_LEN), .RESET_VAL(IDLE_PATTERN)) u_chain (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_capture(tck_rise & cap_s),
        .i_shift(tck_rise & shf_s),
        .i_update(tck_fall & upd_s),
        .i_si(tdi_s),
        .i_par(par),
        .o_update(upd),
        .o_so(chain_so)
    );

    // tdo changes on the falling test clock so the controller samples it stable
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tdo <= 1'b0;
        end else if (tck_fall & shf_s) begin
            o_tdo <= chain_so;
        end
    end

    // (RL1) test drives the core in extest
    assign src = extest_s ? upd : func;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drive <= IDLE_PATTERN;
        end else begin
            drive <= src;
        end
    end

    // (RL3) core power cell
    assign o_converter_power_on = drive[POS_CONV_PWR];
    // (RL4) amplifier power cell
    assign o_amp_power_on = drive[POS_AMP_PWR];
    // (RL5) switched-cap clock cell
    assign o_switchcap_clock = drive[POS_SC_CLK];
    // (RL6) amplifier path cell
    assign o_amp_path_enable = drive[POS_AMP_PATH];
    // (RL7) band-gap negative cell
    assign o_bandgap_neg_select = drive[POS_BG_NEG];
    // (RL8) comparison value cells
    assign o_dac = drive[POS_DAC_LSB +: DAC_W];
    // (RL9) bypass channel cell
    assign o_bypass_ch_connect = drive[POS_BYPASS];
    // (RL10) negative ground cell
    assign o_neg_input_ground = drive[POS_NEG_GND];
    // (RL11) sample and hold cell
    assign o_hold = drive[POS_HOLD];
    // (RL13) band-gap reference cell
    assign o_bandgap_as_reference = drive[POS_BG_REF];
    // (RL14) channel select cells
    assign o_input_select = drive[POS_SEL_LSB +: SEL_W];

    // write channel: address and data taken in either order
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == ADDR_FUNC) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                // both channels reopen only once the response is taken
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // lanes merged on a full word; bits above the chain are dropped
    always_comb begin
        wr_merge = 32'(func);
        for (int k = 0; k < 4; k++) begin
            if (w_strb[k]) begin
                wr_merge[8*k +: 8] = w_data[8*k +: 8];
            end
        end
        // the result bit is an input, never stored
        wr_merge[POS_COMP] = 1'b0;
    end

    // functional controls: what the digital side applies outside extest
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            func <= IDLE_PATTERN;
        end else if (aw_held && w_held && !s_axi_bvalid && aw_addr == ADDR_FUNC) begin
            func <= wr_merge[CHAIN_LEN-1:0];
        end
    end

    // read channel: one cycle from address to data
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_OKAY;
        unique case (s_axi_araddr)
            ADDR_FUNC: next_rdata[CHAIN_LEN-1:0] = func;
            ADDR_STATUS: begin
                next_rdata[STAT_COMP] = comp_s;
                next_rdata[STAT_EXTEST] = extest_s;
                next_rdata[STAT_MID_OK] = (o_dac == DAC_MIDPOINT);
            end
            ADDR_SCAN: next_rdata[CHAIN_LEN-1:0] = upd;
            default: next_rresp = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_drive_follows_src: assert property (##1 drive == $past(src)) // RL1
        else $error("applied controls do not follow selected source");
    chk_idle_applied: assert property ( // RL2
        (extest_s && upd == IDLE_PATTERN)[*2] |-> drive == IDLE_PATTERN)
        else $error("idle pattern not applied");
    chk_comp_captured: assert property ( // RL2
        tck_rise && cap_s |=> u_chain.shreg[POS_COMP] == $past(comp_s))
        else $error("comparator cell missed the result");
    chk_conv_power: assert property ( // RL3
        $rose(o_converter_power_on) |-> $past(src[POS_CONV_PWR]))
        else $error("core power rose without a cause");
    chk_amp_power: assert property ( // RL4
        extest_s && !upd[POS_AMP_PWR] |=> !o_amp_power_on)
        else $error("amplifier powered while cell is 0");
    chk_hold_and_clock: assert property ( // RL11
        extest_s ##1 extest_s |-> o_hold == $past(upd[POS_HOLD]) && o_switchcap_clock == $past(upd[POS_SC_CLK]))
        else $error("hold or switched-cap clock wrong");
    chk_dac_and_select: assert property ( // RL8
        $changed(o_dac) || $changed(o_input_select) |-> $past(src[POS_DAC_LSB +: DAC_W]) == o_dac
            && $past(src[POS_SEL_LSB +: SEL_W]) == o_input_select)
        else $error("value or channel select wrong");
    chk_path_cells: assert property ( // RL6
        ##1 {o_amp_path_enable, o_bandgap_neg_select, o_bypass_ch_connect, o_neg_input_ground,
            o_bandgap_as_reference} == $past({src[POS_AMP_PATH], src[POS_BG_NEG], src[POS_BYPASS],
            src[POS_NEG_GND], src[POS_BG_REF]}))
        else $error("path control cells wrong");
    chk_tdo_shift: assert property (
        tck_fall && shf_s |=> o_tdo == $past(chain_so))
        else $error("tdo did not present the chain output");
    chk_write_resp: assert property (
        aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write response missing");
    chk_busy_ready: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open while a response is pending");
    chk_read_resp: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data missing after address");
    chk_func_result: assert property (!func[POS_COMP]) // RL1
        else $error("result bit stored in function register");
endmodule

// File: test/adc_boundary_scan_cells_bench.sv
/*
 bench: axi register checks, then extest scans through the tap model.
 assumes adcbs_tap_model as the test controller.
*/
`timescale 1ns/10ps
module adc_boundary_scan_cells_bench;
    import adcbs_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic tck, tdi, cap, sh, upd, ext, comp, tdo;
    logic pwr, apwr, scc, apath, bgn, byp, ngnd, hold, bgr;
    logic [DAC_W-1:0] dac;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int error_cnt = 0;
    int checks_done = 0;
    localparam logic [CHAIN_LEN-1:0] PAT_A = {8'hFE, 4'b1110, 10'h1FF, 5'b11111, 1'b0};
    localparam logic [CHAIN_LEN-1:0] PAT_B = {8'h08, 4'b0001, 10'h123, 5'b00001, 1'b0};
    // sampling forces the midpoint on the value actually applied
    localparam logic [CHAIN_LEN-1:0] PAT_BM = {8'h08, 4'b0001, DAC_MIDPOINT, 5'b00001, 1'b0};
    localparam logic [CHAIN_LEN-1:0] PAT_C = {8'h01, 4'b0101, 10'h200, 5'b00011, 1'b0};
    // hold rises with the amplifier powered, so the clock cell goes high too
    localparam logic [CHAIN_LEN-1:0] PAT_CS = {8'h01, 4'b0101, 10'h200, 5'b00111, 1'b0};
    localparam logic [31:0] IDLE32 = {4'h0, IDLE_PATTERN};
    always #2.5 i_clk = ~i_clk;
    adcbs_tap_model tap_u (.i_clk(i_clk), .i_tdo(tdo), .o_tck(tck), .o_tdi(tdi), .o_capture_dr(cap),
        .o_shift_dr(sh), .o_update_dr(upd), .o_extest(ext), .o_comp(comp));
    adcbs_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tdi(tdi), .i_capture_dr(cap),
        .i_shift_dr(sh), .i_update_dr(upd), .i_extest(ext), .o_tdo(tdo), .i_comp(comp),
        .o_converter_power_on(pwr), .o_amp_power_on(apwr), .o_switchcap_clock(scc),
        .o_amp_path_enable(apath), .o_bandgap_neg_select(bgn), .o_dac(dac), .o_bypass_ch_connect(byp),
        .o_neg_input_ground(ngnd), .o_hold(hold), .o_bandgap_as_reference(bgr), .o_input_select(sel),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    function automatic logic [31:0] outs();
        return {4'h0, sel, bgr, hold, ngnd, byp, dac, bgn, apath, scc, apwr, pwr, 1'b0};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp({30'h0, got}, {30'h0, exp}, "response");
    endtask
    // handshakes are judged at negedge, the values the next rising edge samples
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ha, hw, hb;
        logic [1:0] r;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge i_clk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid & bready;
            r = bresp;
            @(posedge i_clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end while (hb !== 1'b1);
        bready <= 1'b0;
        cmp_resp(r, er);
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ha, hr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge i_clk);
            ha = arvalid & arready;
            hr = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge i_clk);
            if (ha) arvalid <= 1'b0;
        end while (hr !== 1'b1);
        rready <= 1'b0;
        cmp(d, ed, "read data");
        cmp_resp(r, er);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // long enough for the axi part and five full scans
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        logic [CHAIN_LEN-1:0] got;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        cmp(outs(), IDLE32, "idle outputs");
        axr(ADDR_FUNC, IDLE32, RESP_OKAY);
        axr(ADDR_STATUS, 32'h0000_0004, RESP_OKAY);
        axr(12'h00C, 32'h0000_0000, RESP_SLVERR);
        axw(ADDR_FUNC, {4'hF, PAT_A[27:1], 1'b1}, 4'hF, RESP_OKAY);
        axr(ADDR_FUNC, {4'h0, PAT_A}, RESP_OKAY);
        repeat (3) @(posedge i_clk);
        cmp(outs(), {4'h0, PAT_A}, "func outputs");
        axw(ADDR_FUNC, 32'h0000_0000, 4'b0100, RESP_OKAY);
        axr(ADDR_FUNC, {4'h0, PAT_A} & 32'hFF00_FFFF, RESP_OKAY);
        axw(ADDR_SCAN, 32'h0000_0000, 4'hF, RESP_SLVERR);
        axr(ADDR_FUNC, {4'h0, PAT_A} & 32'hFF00_FFFF, RESP_OKAY);
        axr(ADDR_SCAN, IDLE32, RESP_OKAY);
        tap_u.mode(1'b1, 1'b1);
        cmp(outs(), IDLE32, "extest idle");
        axr(ADDR_STATUS, 32'h0000_0007, RESP_OKAY);
        tap_u.scan(PAT_A, got);
        cmp({4'h0, got}, {4'h0, IDLE_PATTERN[27:1], 1'b1}, "capture one");
        repeat (4) @(posedge i_clk);
        cmp(outs(), {4'h0, PAT_A}, "scan a");
        tap_u.scan(PAT_B, got);
        cmp({4'h0, got}, {4'h0, PAT_A[27:1], 1'b1}, "capture two");
        repeat (4) @(posedge i_clk);
        cmp(outs(), {4'h0, PAT_BM}, "scan b");
        tap_u.mode(1'b1, 1'b0);
        tap_u.scan(PAT_C, got);
        cmp({4'h0, got}, {4'h0, PAT_BM}, "capture three");
        repeat (4) @(posedge i_clk);
        cmp(outs(), {4'h0, PAT_CS}, "scan c");
        tap_u.scan(IDLE_PATTERN, got);
        cmp({4'h0, got}, {4'h0, PAT_CS}, "capture four");
        repeat (4) @(posedge i_clk);
        cmp(outs(), IDLE32, "scan idle");
        tap_u.scan(IDLE_PATTERN, got);
        cmp({4'h0, got}, IDLE32, "idle capture");
        tap_u.mode(1'b0, 1'b0);
        cmp(outs(), {4'h0, PAT_A} & 32'hFF00_FFFF, "back to func");
        final_report();
    end
endmodule

// File: test/adcbs_tap_model.sv
/*
 partner: boundary-scan test controller driving tck, tdi and the tap state levels.
 assumes the segment samples every pin through a two-flop synchroniser on i_clk.
*/
`timescale 1ns/10ps
module adcbs_tap_model
    import adcbs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_tdo,
    output logic o_tck,
    output logic o_tdi,
    output logic o_capture_dr,
    output logic o_shift_dr,
    output logic o_update_dr,
    output logic o_extest,
    output logic o_comp
);
    logic [CHAIN_LEN-1:0] applied;
    initial begin
        {o_tck, o_tdi, o_capture_dr, o_shift_dr, o_update_dr, o_extest, o_comp} = '0;
        applied = IDLE_PATTERN;
    end
    // four clocks per level, one spare over the synchroniser
    task automatic wait4();
        repeat (4) @(posedge i_clk);
    endtask
    task automatic tck_to(input logic lvl);
        wait4();
        o_tck <= lvl;
        wait4();
    endtask
    task automatic mode(input logic ext, input logic cmp);
        @(posedge i_clk);
        o_extest <= ext;
        o_comp <= cmp;
        repeat (2) wait4();
    endtask
    task automatic scan(input logic [CHAIN_LEN-1:0] vin, output logic [CHAIN_LEN-1:0] vout);
        logic [CHAIN_LEN-1:0] v;
        v = vin;
        if (!v[POS_HOLD]) v[POS_DAC_LSB +: DAC_W] = DAC_MIDPOINT;
        if (v[POS_AMP_PWR] && v[POS_HOLD] && !applied[POS_HOLD]) v[POS_SC_CLK] = 1'b1;
        @(posedge i_clk);
        o_capture_dr <= 1'b1;
        tck_to(1'b1);
        o_capture_dr <= 1'b0;
        o_shift_dr <= 1'b1;
        tck_to(1'b0);
        for (int i = 0; i < CHAIN_LEN; i++) begin
            vout[i] = i_tdo;
            o_tdi <= v[i];
            tck_to(1'b1);
            // between bits the line is not held, so show the inverse
            o_tdi <= ~v[i];
            if (i == CHAIN_LEN - 1) begin
                o_shift_dr <= 1'b0;
            end
            tck_to(1'b0);
        end
        o_update_dr <= 1'b1;
        tck_to(1'b1);
        tck_to(1'b0);
        o_update_dr <= 1'b0;
        applied = v;
    endtask
endmodule
